// >>> tb/scan_read_session_timing_tb.sv
/*
 self-checking bench for srt_top: register rows, boot, sessions, save.
 assumes srt_host_model as host and ms ticks shortened to 4 cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module scan_read_session_timing_tb;
    import srt_pkg::*;
    localparam int MS = 4;
    logic clk_sys = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
    logic avs_waitrequest, imaging_active, good_read_lamp_n, beeper_n, ready;
    logic save_busy, ack_pulse, decode_good, nvm_done, pull_trig = 1'b0, want_good = 1'b0;
    logic rts, lpi, dab;
    srt_pins_type pins;
    int err_count = 0, checks_done = 0;
    typedef struct { logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; } row_type;
    row_type rows [7] = '{'{0, 8'h14, 0, 32'h0000_00C8}, '{0, 8'h18, 0, 32'h0000_0032},
        '{0, 8'h1C, 0, 32'h0000_0005}, '{0, 8'h0C, 0, 32'h0000_0000},
        '{0, 8'h10, 0, 32'h0000_0000}, '{1, 8'h24, 32'h0000_1234, 32'h0000_0000},
        '{1, 8'h10, 32'h0000_0042, 32'h0000_0042}};
    initial forever #25 clk_sys = ~clk_sys;
    srt_top #(.MS_CYCLES(MS)) dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pins(pins),
        .fast_boot_strap(1'b0), .usb_suspend(1'b0), .image_done(1'b0),
        .decode_good(decode_good), .auto_window_done(1'b0), .nvm_done(nvm_done),
        .imaging_active(imaging_active), .decode_abort(dab), .good_read_lamp_n(good_read_lamp_n),
        .beeper_n(beeper_n), .low_power_indicator(lpi), .request_to_send(rts), .ready(ready),
        .save_busy(save_busy), .ack_pulse(ack_pulse));
    srt_host_model host (.clk_sys(clk_sys), .pull_trig(pull_trig), .want_good(want_good),
        .imaging_active(imaging_active), .save_busy(save_busy), .pins(pins),
        .decode_good(decode_good), .nvm_done(nvm_done));
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // holds the request until waitrequest is sampled low, then one idle edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        forever begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wait_ms(input int m);
        repeat (m * MS) @(posedge clk_sys);
    endtask
    task automatic wait_for(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 4000) begin
            @(posedge clk_sys);
            n++;
        end
        chk("handshake", 32'(v), 32'(s));
    endtask
    initial begin
        repeat (40000) @(posedge clk_sys);
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 32'h0000_0000);
            chk("reg", rows[i].e, rd);
        end
        wait_ms(490);
        chk("ready early", 32'h0, 32'(ready));
        chk("rts not ready", 32'h1, 32'(rts));
        wait_ms(25);
        chk("ready boot", 32'h1, 32'(ready));
        chk("rts ready", 32'h0, 32'(rts));
        chk("lowp flag", 32'h0, 32'(lpi));
        bus(1'b1, 8'h0C, 32'h0000_0002); // 20 ms delay
        bus(1'b1, 8'h04, 32'h0000_0001);
        wait_ms(12);
        chk("in delay", 32'h0, 32'(imaging_active));
        wait_ms(12);
        chk("after delay", 32'h1, 32'(imaging_active));
        bus(1'b1, 8'h04, 32'h0000_0002);
        wait_ms(1);
        chk("stopped", 32'h0, 32'(imaging_active));
        bus(1'b1, 8'h0C, 32'h0000_0000);
        bus(1'b1, 8'h08, 32'h0001_0005); // timed, 0005 x 10 ms
        bus(1'b1, 8'h04, 32'h0000_0001);
        wait_ms(35);
        chk("window open", 32'h1, 32'(imaging_active));
        wait_for(dab, 1'b1);
        wait_ms(20);
        chk("window shut", 32'h0, 32'(imaging_active));
        bus(1'b1, 8'h08, 32'h0000_0000);
        pull_trig <= 1'b1;
        wait_ms(30);
        chk("trig held", 32'h1, 32'(imaging_active));
        pull_trig <= 1'b0;
        wait_ms(2);
        chk("trig gone", 32'h0, 32'(imaging_active));
        want_good <= 1'b1;
        bus(1'b1, 8'h04, 32'h0000_0001);
        wait_for(good_read_lamp_n, 1'b0);
        wait_ms(2);
        chk("session end", 32'h0, 32'(imaging_active));
        wait_ms(43);
        chk("beep on", 32'h0, 32'(beeper_n));
        wait_ms(10);
        chk("beep off", 32'h1, 32'(beeper_n));
        wait_ms(140);
        chk("lamp on", 32'h0, 32'(good_read_lamp_n));
        wait_ms(10);
        chk("lamp off", 32'h1, 32'(good_read_lamp_n));
        bus(1'b1, 8'h00, 32'h0000_0003); // ack enabled, flow mode
        chk("rts flow", 32'h1, 32'(rts));
        bus(1'b1, 8'h04, 32'h0000_0004);
        wait_for(ack_pulse, 1'b1);
        chk("ack after save", 32'h0, 32'(save_busy));
        tally_and_finish();
    end
endmodule
`default_nettype wire

// >>> tb/srt_host_model.sv
/*
 host side of the read session timer: trigger pin, decoder and flash.
 assumes srt_pkg and one clock shared with the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module srt_host_model (
    input  wire logic            clk_sys,
    input  wire logic            pull_trig,
    input  wire logic            want_good,
    input  wire logic            imaging_active,
    input  wire logic            save_busy,
    output var srt_pkg::srt_pins_type pins,
    output logic                 decode_good,
    output logic                 nvm_done
);
    import srt_pkg::*;
    logic [7:0] img_cnt;
    logic [7:0] save_cnt;
    initial begin
        pins = '{1'b1, 1'b1, 1'b1};
        decode_good = 1'b0;
        nvm_done = 1'b0;
        img_cnt = '0;
        save_cnt = '0;
    end
    // plain always: the initial block also sets these for the reset cycles
    always @(posedge clk_sys) begin
        pins <= '{~pull_trig, 1'b1, 1'b1};
        img_cnt <= (imaging_active && want_good) ? img_cnt + 8'h01 : 8'h00;
        decode_good <= (img_cnt == 8'h03); // one decode per session
        save_cnt <= save_busy ? save_cnt + 8'h01 : 8'h00;
        nvm_done <= (save_cnt == 8'h05); // power stays on meanwhile
    end
endmodule
`default_nettype wire

// >>> verilog/srt_defines.svh
/*
 offsets, reset values and timing figures of the read session timer.
 assumes the includer uses 32-bit register data and byte addresses.
*/
`ifndef SRT_DEFINES_SVH
`define SRT_DEFINES_SVH
`define SRT_CLK_HZ        20000000
`define SRT_MS_PER_S      1000
`define SRT_OFS_CONFIG    8'h00
`define SRT_OFS_COMMAND   8'h04
`define SRT_OFS_WINDOW    8'h08
`define SRT_OFS_DELAY     8'h0C
`define SRT_OFS_DEC_LIM   8'h10
`define SRT_OFS_LAMP      8'h14
`define SRT_OFS_BEEP      8'h18
`define SRT_OFS_STANDBY   8'h1C
`define SRT_OFS_STATUS    8'h20
`define SRT_CMD_START     0
`define SRT_CMD_STOP      1
`define SRT_CMD_SAVE      2
`define SRT_CMD_DUMMY     3
`define SRT_BOOT_NORM_MS  20'd510
`define SRT_BOOT_FAST_MS  20'd425
`define SRT_WAKE_A_MS     20'd18
`define SRT_WAKE_B_MS     20'd43
`define SRT_LAMP_DEF_MS   16'h00C8
`define SRT_BEEP_DEF_MS   16'h0032
`define SRT_SAVE_MAX_MS   14'd10000
`define SRT_STANDBY_DEF_S 14'd5
`define SRT_STANDBY_0_MS  24'd150
`define SRT_S_TO_MS       24'd1000
`define SRT_UNIT_10MS     20'd10
`define SRT_TEN_PER_10MS  4'd9
`define SRT_S_PER_10MS    7'd99
`define SRT_TEN_IMAGES    4'd10
`define SRT_BCD_W3        18'd1000
`define SRT_BCD_W2        18'd100
`define SRT_BCD_W1        18'd10
`endif

// >>> verilog/srt_pkg.sv
/*
 types of the read session timer.
 takes no numbers from srt_defines.svh; the state and window mode codes stand here.
*/
`default_nettype none
package srt_pkg;
    typedef enum logic [5:0] {
        ST_BOOT  = 6'b000001,
        ST_IDLE  = 6'b000010,
        ST_DELAY = 6'b000100,
        ST_READ  = 6'b001000,
        ST_LOWP  = 6'b010000,
        ST_WAKE  = 6'b100000
    } srt_state_type;
    typedef enum logic [1:0] {
        WIN_TRIG_SYNC = 2'h0,
        WIN_TIMED     = 2'h1,
        WIN_UNLIMITED = 2'h2,
        WIN_TEN_TIMES = 2'h3
    } srt_win_type;
    typedef struct packed {
        logic low_power_en;
        logic usb_mode;
        logic variant_slow;
        logic count_from_start;
        logic auto_trigger;
        logic ack_enable;
        logic hardware_flow_mode;
    } srt_cfg_type;
    typedef struct packed {
        logic scan_trigger_n;
        logic cts_n;
        logic wake_n_a;
    } srt_pins_type;
endpackage
`default_nettype wire

// >>> verilog/srt_top.sv
/*
 read session timer: boot, low power wake, trigger delay, read window,
 decode limit, good-read lamp and beeper, settings save with ack.
 assumes pins synchronous to clk_sys and an avalon-mm master.
*/
// Functional notes
// RULE1: over USB a pin wake leaves low power, ready after recovery time.
// RULE2: over USB commands are taken in low power and return it active.
// RULE3: recovery lasts 18 ms on one variant, 43 ms on the other.
// RULE4: after power-on, ready after 510 ms, or 425 ms with fast boot.
// RULE5: in hardware flow mode request-to-send is held high.
// RULE6: saving settings may take up to 10 s; keep power on meanwhile.
// RULE7: acknowledge is sent only after the save has finished.
// RULE8: good read pulses the active-low lamp, default 200 ms.
// RULE9: good read pulses the active-low beeper, default 50 ms.
// RULE10: session starts on trigger or start command, ends when window expires.
// RULE11: window modes: trigger sync, 1 to 9 s, unlimited, ten times.
// RULE12: auto trigger with trigger sync takes window end from imaging.
// RULE13: window may be a four-digit decimal count of 10 ms.
// RULE14: in trigger sync mode reading lasts while the trigger is held.
// RULE15: timed window counts from trigger release, or assertion if chosen.
// RULE16: start command begins reading, stop command ends it.
// RULE17: command-started read stops at window end or on stop command.
// RULE18: trigger delay, four decimal digits of 10 ms, default 0.
// RULE19: decode time per image limited in 1 ms units, then next image.
// RULE20: decode limit of zero disables the limit.
// RULE21: after standby time enter low power and raise the indicator.
// RULE22: numeric settings arrive as four decimal digits; the code takes lamp, beeper and standby times as binary.
// RULE23: session ends on decoded output unless unlimited.
`timescale 1ns/1ns
`default_nettype none
`include "srt_defines.svh"
module srt_top #(
    parameter int MS_CYCLES = `SRT_CLK_HZ / `SRT_MS_PER_S
) (
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic [7:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    output logic [31:0]              avs_readdata,
    output logic                     avs_waitrequest,
    input  wire srt_pkg::srt_pins_type pins,
    input  wire logic                fast_boot_strap,
    input  wire logic                usb_suspend,
    input  wire logic                image_done,
    input  wire logic                decode_good,
    input  wire logic                auto_window_done,
    input  wire logic                nvm_done,
    output logic                     imaging_active,
    output logic                     decode_abort,
    output logic                     good_read_lamp_n,
    output logic                     beeper_n,
    output logic                     low_power_indicator,
    output logic                     request_to_send,
    output logic                     ready,
    output logic                     save_busy,
    output logic                     ack_pulse
);
    import srt_pkg::*;

    function automatic logic [13:0] bcd_to_bin(input logic [15:0] b);
        logic [17:0] s;
        s = 18'(b[15:12]) * `SRT_BCD_W3 + 18'(b[11:8]) * `SRT_BCD_W2
          + 18'(b[7:4]) * `SRT_BCD_W1 + 18'(b[3:0]);
        return s[13:0];
    endfunction

    // bus and register group
    srt_cfg_type cfg_q, cfg_d;
    logic [17:0] win_q, win_d;
    logic [15:0] dly_q, dly_d, lim_q, lim_d;
    logic [15:0] lamp_ms_q, lamp_ms_d, beep_ms_q, beep_ms_d;
    logic [13:0] stby_q, stby_d;
    logic [3:0]  cmd_q, cmd_d;
    logic        ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic        boot_fast_q, boot_fast_d;
    logic        req, wr_acc;
    // engine group
    srt_state_type st_q, st_d;
    logic [14:0] div_q, div_d;
    logic [3:0]  t10_q, t10_d;
    logic [6:0]  sdiv_q, sdiv_d;
    logic        ms_tick, t10_tick;
    logic [19:0] tmr_q, tmr_d;
    logic [13:0] win_cnt_q, win_cnt_d, img_q, img_d, save_q, save_d;
    logic [23:0] idle_q, idle_d;
    logic [15:0] lamp_q, lamp_d, beep_q, beep_d;
    logic [3:0]  shots_q, shots_d;
    logic        by_trig_q, by_trig_d, pend_q, pend_d, trig_prev_q;
    logic        abort_q, abort_d, ackp_q, ackp_d, saving_q, saving_d;
    logic        released_q, released_d;
    logic        trig_on, trig_fall, wake_pin, good_evt, win_over, stop_now;
    logic [19:0] wake_ms, boot_ms, dly_ms;
    logic [13:0] win_val, lim_val;
    logic [23:0] stby_ms;
    srt_win_type win_mode;

    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign wr_acc          = avs_write & ack_q;
    assign avs_readdata    = rdata_q;

    always_comb begin
        ack_d       = req & ~ack_q;
        cfg_d       = cfg_q;
        win_d       = win_q;
        dly_d       = dly_q;
        lim_d       = lim_q;
        lamp_ms_d   = lamp_ms_q;
        beep_ms_d   = beep_ms_q;
        stby_d      = stby_q;
        cmd_d       = 4'h0;
        boot_fast_d = boot_fast_q;
        rdata_d     = rdata_q;
        if (req & ~ack_q) begin
            // one wait state, read data stands at the accepting edge
            unique case (avs_address)
                `SRT_OFS_CONFIG:  rdata_d = 32'(cfg_q);
                `SRT_OFS_WINDOW:  rdata_d = 32'(win_q);
                `SRT_OFS_DELAY:   rdata_d = 32'(dly_q);
                `SRT_OFS_DEC_LIM: rdata_d = 32'(lim_q);
                `SRT_OFS_LAMP:    rdata_d = 32'(lamp_ms_q);
                `SRT_OFS_BEEP:    rdata_d = 32'(beep_ms_q);
                `SRT_OFS_STANDBY: rdata_d = 32'(stby_q);
                `SRT_OFS_STATUS:  rdata_d = {18'h0_0000, saving_q, ready,
                                             low_power_indicator, boot_fast_q, 4'h0,
                                             st_q};
                default:          rdata_d = 32'h0000_0000;
            endcase
        end
        if (wr_acc) begin
            unique case (avs_address)
                `SRT_OFS_CONFIG:  cfg_d     = avs_writedata[$bits(srt_cfg_type)-1:0];
                `SRT_OFS_COMMAND: cmd_d     = avs_writedata[3:0];
                `SRT_OFS_WINDOW:  win_d     = avs_writedata[17:0];
                `SRT_OFS_DELAY:   dly_d     = avs_writedata[15:0];
                `SRT_OFS_DEC_LIM: lim_d     = avs_writedata[15:0];
                `SRT_OFS_LAMP:    lamp_ms_d = avs_writedata[15:0];
                `SRT_OFS_BEEP:    beep_ms_d = avs_writedata[15:0];
                `SRT_OFS_STANDBY: stby_d    = avs_writedata[13:0];
                default:          ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_q       <= 1'b0;
            cfg_q       <= '0;
            win_q       <= '0;
            dly_q       <= 16'h0000;
            lim_q       <= 16'h0000;
            lamp_ms_q   <= `SRT_LAMP_DEF_MS;
            beep_ms_q   <= `SRT_BEEP_DEF_MS;
            stby_q      <= `SRT_STANDBY_DEF_S;
            cmd_q       <= 4'h0;
            rdata_q     <= 32'h0000_0000;
            boot_fast_q <= fast_boot_strap; // strap caught while reset is held
        end else begin
            ack_q       <= ack_d;
            cfg_q       <= cfg_d;
            win_q       <= win_d;
            dly_q       <= dly_d;
            lim_q       <= lim_d;
            lamp_ms_q   <= lamp_ms_d;
            beep_ms_q   <= beep_ms_d;
            stby_q      <= stby_d;
            cmd_q       <= cmd_d;
            rdata_q     <= rdata_d;
            boot_fast_q <= boot_fast_d;
        end
    end

    // engine group
    assign win_mode  = srt_win_type'(win_q[17:16]);
    assign win_val   = bcd_to_bin(win_q[15:0]);                         // [RULE13] [RULE22]
    assign dly_ms    = 20'(bcd_to_bin(dly_q)) * `SRT_UNIT_10MS;         // [RULE18] [RULE22]
    assign lim_val   = bcd_to_bin(lim_q);                               // [RULE19] [RULE22]
    assign wake_ms   = cfg_q.variant_slow ? `SRT_WAKE_B_MS : `SRT_WAKE_A_MS; // [RULE3]
    assign boot_ms   = boot_fast_q ? `SRT_BOOT_FAST_MS : `SRT_BOOT_NORM_MS;  // [RULE4]
    assign stby_ms   = (stby_q == 14'd0) ? `SRT_STANDBY_0_MS
                                         : 24'(stby_q) * `SRT_S_TO_MS;
    assign ms_tick   = (div_q == 15'(MS_CYCLES - 1));
    assign t10_tick  = ms_tick & (t10_q == `SRT_TEN_PER_10MS);
    assign trig_on   = ~pins.scan_trigger_n;
    assign trig_fall = trig_on & trig_prev_q;
    assign wake_pin  = trig_on | ~pins.cts_n | ~pins.wake_n_a;
    assign good_evt  = decode_good & (st_q == ST_READ);
    assign win_over  = (win_cnt_q >= win_val);

    always_comb begin
        st_d       = st_q;
        div_d      = ms_tick ? 15'd0 : div_q + 15'd1;
        t10_d      = t10_tick ? 4'd0 : (ms_tick ? t10_q + 4'd1 : t10_q);
        sdiv_d     = sdiv_q;
        tmr_d      = ms_tick ? tmr_q + 20'd1 : tmr_q;
        win_cnt_d  = win_cnt_q;
        img_d      = img_q;
        idle_d     = idle_q;
        lamp_d     = (ms_tick && lamp_q != 16'd0) ? lamp_q - 16'd1 : lamp_q;
        beep_d     = (ms_tick && beep_q != 16'd0) ? beep_q - 16'd1 : beep_q;
        shots_d    = shots_q;
        by_trig_d  = by_trig_q;
        pend_d     = pend_q | cmd_q[`SRT_CMD_START];
        abort_d    = 1'b0;
        ackp_d     = 1'b0;
        saving_d   = saving_q;
        save_d     = save_q;
        released_d = released_q;
        stop_now   = 1'b0;
        sdiv_d     = 7'd0;
        // settings save runs beside the session; power must stay up meanwhile
        if (cmd_q[`SRT_CMD_SAVE]) begin
            saving_d = 1'b1; // [RULE6]
            save_d   = 14'd0;
        end else if (saving_q) begin
            if (ms_tick)
                save_d = save_q + 14'd1;
            if (nvm_done || save_q >= `SRT_SAVE_MAX_MS) begin
                saving_d = 1'b0;
                ackp_d   = cfg_q.ack_enable; // [RULE7]
            end
        end
        if (good_evt) begin
            lamp_d = lamp_ms_q; // [RULE8]
            beep_d = beep_ms_q; // [RULE9]
        end
        unique case (st_q)
            ST_BOOT: begin
                if (tmr_q >= boot_ms) // [RULE4]
                    st_d = ST_IDLE;
            end
            ST_IDLE: begin
                idle_d = ms_tick ? idle_q + 24'd1 : idle_q;
                if (trig_fall || pend_q) begin // [RULE10] [RULE16]
                    st_d      = ST_DELAY;
                    by_trig_d = trig_fall;
                    pend_d    = 1'b0;
                    tmr_d     = 20'd0;
                end else if (cfg_q.low_power_en && idle_q >= stby_ms
                             && (!cfg_q.usb_mode || usb_suspend)) begin
                    st_d = ST_LOWP; // [RULE21]
                end
            end
            ST_DELAY: begin
                if (cmd_q[`SRT_CMD_STOP])
                    st_d = ST_IDLE;
                else if (tmr_q >= dly_ms) begin // [RULE18]
                    st_d       = ST_READ;
                    win_cnt_d  = 14'd0;
                    img_d      = 14'd0;
                    shots_d    = 4'd0;
                    released_d = ~trig_on;
                end
            end
            ST_READ: begin
                if (trig_fall && by_trig_q)
                    released_d = 1'b0;
                else if (!trig_on)
                    released_d = 1'b1;
                // decode limit per image, zero means no limit
                if (image_done) begin
                    img_d   = 14'd0;
                    shots_d = shots_q + 4'd1;
                end else if (lim_val != 14'd0 && img_q >= lim_val) begin // [RULE20]
                    img_d   = 14'd0;
                    abort_d = 1'b1; // [RULE19]
                end else if (ms_tick)
                    img_d = img_q + 14'd1;
                // timed window counts from release unless start is chosen
                if (t10_tick && (!by_trig_q || cfg_q.count_from_start
                                 || released_q)) // [RULE15]
                    win_cnt_d = win_cnt_q + 14'd1;
                unique case (win_mode)
                    WIN_TRIG_SYNC: begin
                        if (by_trig_q)
                            stop_now = cfg_q.auto_trigger ? auto_window_done // [RULE12]
                                                          : !trig_on; // [RULE14]
                    end
                    WIN_TIMED:     stop_now = win_over && (!by_trig_q || !trig_on
                                              || cfg_q.count_from_start); // [RULE10] [RULE11]
                    WIN_UNLIMITED: stop_now = 1'b0; // [RULE11]
                    WIN_TEN_TIMES: stop_now = (shots_q >= `SRT_TEN_IMAGES); // [RULE11]
                endcase
                if (cmd_q[`SRT_CMD_STOP]) // [RULE16] [RULE17]
                    stop_now = 1'b1;
                if (good_evt && win_mode != WIN_UNLIMITED) // [RULE23]
                    stop_now = 1'b1;
                if (stop_now) begin
                    st_d   = ST_IDLE;
                    idle_d = 24'd0;
                end
            end
            ST_LOWP: begin
                if (cfg_q.usb_mode && cmd_q != 4'h0) begin
                    st_d   = ST_IDLE; // [RULE2]
                    idle_d = 24'd0;
                end else if (wake_pin || cmd_q[`SRT_CMD_DUMMY]) begin
                    st_d  = ST_WAKE; // [RULE1]
                    tmr_d = 20'd0;
                end
            end
            ST_WAKE: begin
                if (tmr_q >= wake_ms) begin // [RULE1] [RULE3]
                    st_d   = ST_IDLE;
                    idle_d = 24'd0;
                end
            end
            default: st_d = ST_BOOT;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q        <= ST_BOOT;
            div_q       <= 15'd0;
            t10_q       <= 4'd0;
            sdiv_q      <= 7'd0;
            tmr_q       <= 20'd0;
            win_cnt_q   <= 14'd0;
            img_q       <= 14'd0;
            idle_q      <= 24'd0;
            lamp_q      <= 16'd0;
            beep_q      <= 16'd0;
            shots_q     <= 4'd0;
            by_trig_q   <= 1'b0;
            pend_q      <= 1'b0;
            abort_q     <= 1'b0;
            ackp_q      <= 1'b0;
            saving_q    <= 1'b0;
            save_q      <= 14'd0;
            released_q  <= 1'b0;
            trig_prev_q <= 1'b1; // idle pin level, so no false edge after reset
        end else begin
            st_q        <= st_d;
            div_q       <= div_d;
            t10_q       <= t10_d;
            sdiv_q      <= sdiv_d;
            tmr_q       <= tmr_d;
            win_cnt_q   <= win_cnt_d;
            img_q       <= img_d;
            idle_q      <= idle_d;
            lamp_q      <= lamp_d;
            beep_q      <= beep_d;
            shots_q     <= shots_d;
            by_trig_q   <= by_trig_d;
            pend_q      <= pend_d;
            abort_q     <= abort_d;
            ackp_q      <= ackp_d;
            saving_q    <= saving_d;
            save_q      <= save_d;
            released_q  <= released_d;
            trig_prev_q <= pins.scan_trigger_n;
        end
    end

    assign imaging_active      = (st_q == ST_READ);
    assign decode_abort        = abort_q;
    assign good_read_lamp_n    = (lamp_q == 16'd0);
    assign beeper_n            = (beep_q == 16'd0);
    assign low_power_indicator = (st_q == ST_LOWP);
    assign ready               = (st_q != ST_BOOT) && (st_q != ST_LOWP) && (st_q != ST_WAKE);
    // flow mode owns this pin, so it cannot report readiness
    assign request_to_send     = cfg_q.hardware_flow_mode | ~ready; // [RULE5]
    assign save_busy           = saving_q;
    assign ack_pulse           = ackp_q;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_good_in_read;
        decode_good && st_q == ST_READ;
    endsequence

    a_rts_flow_high:  assert property (cfg_q.hardware_flow_mode |-> request_to_send) // [RULE5]
        else $error("rts low in flow mode");
    a_lamp_on_good:   assert property (s_good_in_read ##0 lamp_ms_q != 16'd0
                                       |=> !good_read_lamp_n [*1]) // [RULE8]
        else $error("lamp not lit on good read");
    a_beep_on_good:   assert property (s_good_in_read ##0 beep_ms_q != 16'd0
                                       |=> !beeper_n) // [RULE9]
        else $error("beeper silent on good read");
    a_good_ends_read: assert property (s_good_in_read ##0 win_mode != WIN_UNLIMITED
                                       |=> st_q == ST_IDLE) // [RULE23]
        else $error("session continues after output");
    a_stop_ends_read: assert property (st_q == ST_READ && cmd_q[`SRT_CMD_STOP]
                                       |=> st_q == ST_IDLE) // [RULE17]
        else $error("stop command ignored");
    a_lowp_flag:      assert property ($rose(st_q == ST_LOWP) |-> low_power_indicator
                                       && !ready) // [RULE21]
        else $error("low power not indicated");
    a_wake_hold:      assert property ($rose(st_q == ST_WAKE) |-> (st_q == ST_WAKE) [*8]) // [RULE3]
        else $error("wake recovery too short");
    a_no_limit_zero:  assert property (lim_q == 16'h0000 |=> !decode_abort) // [RULE20]
        else $error("abort with limit disabled");
    a_ack_after_save: assert property (ack_pulse |-> $past(saving_q) && !saving_q) // [RULE7]
        else $error("ack before save finished");
    a_usb_cmd_wakes:  assert property (st_q == ST_LOWP && cfg_q.usb_mode && cmd_q != 4'h0
                                       |=> st_q == ST_IDLE) // [RULE2]
        else $error("usb command left device asleep");
    a_trig_holds:     assert property (st_q == ST_READ && by_trig_q && win_mode == WIN_TRIG_SYNC
                                       && !cfg_q.auto_trigger && trig_on && !decode_good
                                       && !cmd_q[`SRT_CMD_STOP] |=> st_q == ST_READ) // [RULE14]
        else $error("read ended while trigger held");
endmodule
`default_nettype wire
